// *** logic/dbc_pkg.sv ***
// Package: constants and carrier types of the dual bank clock divider block
package dbc_pkg;

  // Bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte addresses
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STAT_ADDR = 8'h04;

  // Control register field positions
  localparam int CTL_MR = 0;
  localparam int CTL_BYP_N = 1;
  localparam int CTL_XSEL = 2;
  localparam int CTL_FB = 3;
  localparam int CTL_OEA = 4;
  localparam int CTL_OEB = 5;
  localparam int CTL_DIVA = 6;
  localparam int CTL_DIVB = 8;
  localparam int CTL_W = 10;
  // Reset value: dividers running, PLL in path, crystal, /25, on, /4, /8
  localparam logic [CTL_W-1:0] CTRL_RST = 10'h3f6;

  // Status register field positions
  localparam int ST_SRC = 0;
  localparam int ST_MR = 1;
  localparam int ST_ACNT = 4;
  localparam int ST_BCNT = 8;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Feedback ratios handed to the analog loop
  localparam logic [5:0] FB_LOW = 6'h19;
  localparam logic [5:0] FB_HIGH = 6'h20;

  // Post-divide ratios, bank A
  localparam logic [3:0] DIVA_0 = 4'h1;
  localparam logic [3:0] DIVA_1 = 4'h2;
  localparam logic [3:0] DIVA_2 = 4'h3;
  localparam logic [3:0] DIVA_3 = 4'h4;
  // Post-divide ratios, bank B
  localparam logic [3:0] DIVB_0 = 4'h2;
  localparam logic [3:0] DIVB_1 = 4'h4;
  localparam logic [3:0] DIVB_2 = 4'h5;
  localparam logic [3:0] DIVB_3 = 4'h8;
  localparam logic [3:0] RATIO_ONE = 4'h1;

  localparam int CNT_W = 3;

  // Master to slave signals of the register bus
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } dbc_axil_req_t;

  // Slave to master signals of the register bus
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } dbc_axil_rsp_t;

endpackage

// *** logic/dbc_divider_select.sv ***
// Module: reference select, bypass and two output divider banks
//
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
// Summary of operation
// - Master reset high holds dividers; true outputs low, complements high.
// - Master reset low lets dividers run; reset default is low.
// - Bypass low routes the selected reference straight to the dividers.
// - Bypass defaults high so the PLL output feeds the dividers.
// - Source select picks crystal or single-ended clock; crystal by default.
// - Feedback ratio is 25 when select low, 32 when high; low default.
// - Bank B enable drives both pairs; low makes both high impedance.
// - Bank A enable drives its pair; low makes it high impedance.
// - Each bank has its own two-bit divide select, default all ones.
// - Bank A has one pair, bank B two pairs with the same clock.
// - Bank A select 00/01/10/11 divides by 1/2/3/4.
// - Bank B select 00/01/10/11 divides by 2/4/5/8.
module dbc_divider_select (
  input wire logic clk,
  input wire logic rstn,
  input wire dbc_pkg::dbc_axil_req_t axi_req,
  output dbc_pkg::dbc_axil_rsp_t axi_rsp,
  input wire logic crystal_input,
  input wire logic ref_clk_in,
  input wire logic pll_vco_in,
  output logic crystal_drive_output,
  output logic [5:0] feedback_ratio,
  output logic bank_a_out_true,
  output logic bank_a_out_comp,
  output logic bank_a_oe,
  output logic bank_b_out0_true,
  output logic bank_b_out0_comp,
  output logic bank_b_out1_true,
  output logic bank_b_out1_comp,
  output logic [1:0] bank_b_oe
);
  import dbc_pkg::*;

  // Pin synchronisers: crystal, single-ended reference, PLL output
  logic [2:0] pin_s1_q, pin_s2_q, pin_s1_d, pin_s2_d;
  // Bus state
  logic [CTL_W-1:0] ctrl_q, ctrl_d;
  logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
  logic [DATA_W-1:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [DATA_W-1:0] rdata_q, rdata_d, stat_word;
  // Divider state
  logic src_q, src_d, src_prev_q, src_prev_d, tick;
  logic [CNT_W-1:0] a_cnt_q, a_cnt_d, b_cnt_q, b_cnt_d;
  logic a_true_q, a_true_d, b_true_q, b_true_d, a_comp_q, a_comp_d;
  logic [1:0] b_pair_q, b_pair_d, b_comp_q, b_comp_d;
  logic a_oe_q, a_oe_d, xdrv_q, xdrv_d;
  logic [1:0] b_oe_q, b_oe_d;
  logic [5:0] fb_q, fb_d;
  logic [3:0] ratio_a, ratio_b;
  logic mr;

  // Two flops per pin; only the second stage feeds logic
  always_comb begin
    pin_s1_d = {pll_vco_in, ref_clk_in, crystal_input};
    pin_s2_d = pin_s1_q;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
    end else begin
      pin_s1_q <= pin_s1_d;
      pin_s2_q <= pin_s2_d;
    end
  end

  assign mr = ctrl_q[CTL_MR];

  // Status word shows live divider state
  always_comb begin
    stat_word = '0;
    stat_word[ST_SRC] = src_q;
    stat_word[ST_MR] = mr;
    stat_word[ST_ACNT +: CNT_W] = a_cnt_q;
    stat_word[ST_BCNT +: CNT_W] = b_cnt_q;
  end

  // Register slave: address and data taken in either order
  always_comb begin
    ctrl_d = ctrl_q;
    aw_hold_d = aw_hold_q;
    aw_addr_d = aw_addr_q;
    w_hold_d = w_hold_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (bvalid_q && axi_req.bready) begin
      bvalid_d = 1'b0;
    end
    if (axi_req.awvalid && awready_q) begin
      aw_hold_d = 1'b1;
      aw_addr_d = axi_req.awaddr;
    end
    if (axi_req.wvalid && wready_q) begin
      w_hold_d = 1'b1;
      w_data_d = axi_req.wdata;
      w_strb_d = axi_req.wstrb;
    end
    // Commit only once the previous response has gone
    if (aw_hold_q && w_hold_q && !bvalid_q) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      if (aw_addr_q[ADDR_W-1:2] == CTRL_ADDR[ADDR_W-1:2]) begin
        if (w_strb_q[0]) begin
          ctrl_d[7:0] = w_data_q[7:0];
        end
        if (w_strb_q[1]) begin
          ctrl_d[CTL_W-1:8] = w_data_q[CTL_W-1:8];
        end
      end else if (aw_addr_q[ADDR_W-1:2] != STAT_ADDR[ADDR_W-1:2]) begin
        bresp_d = RESP_SLVERR; // Unmapped address; status writes are ignored and answered OKAY
      end
    end
    awready_d = !aw_hold_d && !bvalid_d;
    wready_d = !w_hold_d && !bvalid_d;
    if (rvalid_q && axi_req.rready) begin
      rvalid_d = 1'b0;
    end
    if (axi_req.arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      if (axi_req.araddr[ADDR_W-1:2] == CTRL_ADDR[ADDR_W-1:2]) begin
        rdata_d = {{(DATA_W-CTL_W){1'b0}}, ctrl_q};
      end else if (axi_req.araddr[ADDR_W-1:2] == STAT_ADDR[ADDR_W-1:2]) begin
        rdata_d = stat_word;
      end else begin
        rdata_d = '0;
        rresp_d = RESP_SLVERR;
      end
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_q <= CTRL_RST;
      aw_hold_q <= 1'b0;
      aw_addr_q <= '0;
      w_hold_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= 4'h0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else begin
      ctrl_q <= ctrl_d;
      aw_hold_q <= aw_hold_d;
      aw_addr_q <= aw_addr_d;
      w_hold_q <= w_hold_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign axi_rsp = '{awready: awready_q, wready: wready_q,
                     bvalid: bvalid_q, bresp: bresp_q,
                     arready: arready_q, rvalid: rvalid_q,
                     rdata: rdata_q, rresp: rresp_q};

  // Ratio decode per bank, each from its own select
  always_comb begin
    case (ctrl_q[CTL_DIVA +: 2])
      2'h0: ratio_a = DIVA_0;
      2'h1: ratio_a = DIVA_1;
      2'h2: ratio_a = DIVA_2;
      default: ratio_a = DIVA_3;
    endcase
    case (ctrl_q[CTL_DIVB +: 2])
      2'h0: ratio_b = DIVB_0;
      2'h1: ratio_b = DIVB_1;
      2'h2: ratio_b = DIVB_2;
      default: ratio_b = DIVB_3;
    endcase
  end

  assign tick = src_q && !src_prev_q;

  // Source mux and dividers; source must stay below clk/2 to be seen
  always_comb begin
    if (!ctrl_q[CTL_BYP_N]) begin
      src_d = ctrl_q[CTL_XSEL] ? pin_s2_q[0] : pin_s2_q[1];
    end else begin
      src_d = pin_s2_q[2];
    end
    src_prev_d = src_q;
    fb_d = ctrl_q[CTL_FB] ? FB_HIGH : FB_LOW;
    xdrv_d = ctrl_q[CTL_XSEL] & ~pin_s2_q[0];
    a_oe_d = ctrl_q[CTL_OEA];
    b_oe_d = {2{ctrl_q[CTL_OEB]}};
    a_cnt_d = a_cnt_q;
    b_cnt_d = b_cnt_q;
    if (mr) begin
      a_cnt_d = '0;
      b_cnt_d = '0;
    end else if (tick) begin
      a_cnt_d = ({1'b0, a_cnt_q} + 4'h1 >= ratio_a) ? '0 : a_cnt_q + 3'h1;
      b_cnt_d = ({1'b0, b_cnt_q} + 4'h1 >= ratio_b) ? '0 : b_cnt_q + 3'h1;
    end
    // High for the upper half of each count cycle, low from zero; bank A at ratio 1 follows the source
    if (mr) begin
      a_true_d = 1'b0;
      b_true_d = 1'b0;
    end else begin
      a_true_d = (ratio_a == RATIO_ONE) ? src_q :
                 ({a_cnt_d, 1'b0} >= ratio_a);
      b_true_d = ({b_cnt_d, 1'b0} >= ratio_b);
    end
    b_pair_d = {2{b_true_d}};
    a_comp_d = ~a_true_d;
    b_comp_d = ~b_pair_d;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      src_q <= 1'b0;
      src_prev_q <= 1'b0;
      a_cnt_q <= '0;
      b_cnt_q <= '0;
      a_true_q <= 1'b0;
      b_true_q <= 1'b0;
      b_pair_q <= 2'h0;
      a_comp_q <= 1'b1;
      b_comp_q <= 2'h3;
      a_oe_q <= 1'b0;
      b_oe_q <= 2'h0;
      fb_q <= FB_LOW;
      xdrv_q <= 1'b0;
    end else begin
      src_q <= src_d;
      src_prev_q <= src_prev_d;
      a_cnt_q <= a_cnt_d;
      b_cnt_q <= b_cnt_d;
      a_true_q <= a_true_d;
      b_true_q <= b_true_d;
      b_pair_q <= b_pair_d;
      a_comp_q <= a_comp_d;
      b_comp_q <= b_comp_d;
      a_oe_q <= a_oe_d;
      b_oe_q <= b_oe_d;
      fb_q <= fb_d;
      xdrv_q <= xdrv_d;
    end
  end

  // Complements get flops of their own so no pin leaves through a gate
  assign bank_a_out_true = a_true_q;
  assign bank_a_out_comp = a_comp_q;
  assign bank_b_out0_true = b_pair_q[0];
  assign bank_b_out0_comp = b_comp_q[0];
  assign bank_b_out1_true = b_pair_q[1];
  assign bank_b_out1_comp = b_comp_q[1];
  assign bank_a_oe = a_oe_q;
  assign bank_b_oe = b_oe_q;
  assign feedback_ratio = fb_q;
  assign crystal_drive_output = xdrv_q;

  // Checks
  sequence s_mr_release;
    mr ##1 !mr;
  endsequence

  property p_mr_hold;
    @(posedge clk) disable iff (!rstn)
      mr |=> (!bank_a_out_true && bank_a_out_comp && !bank_b_out0_true
              && bank_b_out1_comp);
  endproperty
  a_mr_hold: assert property (p_mr_hold) else $error("reset not low");
  property p_restart;
    @(posedge clk) disable iff (!rstn)
      s_mr_release |-> (a_cnt_q == '0) && (b_cnt_q == '0);
  endproperty
  a_restart: assert property (p_restart) else $error("no restart");
  property p_reset_dflt;
    @(posedge clk) !rstn |=> (ctrl_q == CTRL_RST);
  endproperty
  a_reset_dflt: assert property (p_reset_dflt) else $error("bad default");
  property p_bypass;
    @(posedge clk) disable iff (!rstn)
      !ctrl_q[CTL_BYP_N] && ctrl_q[CTL_XSEL] |=> src_q == $past(pin_s2_q[0]);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass path");
  property p_fb;
    @(posedge clk) disable iff (!rstn)
      ##1 fb_q == ($past(ctrl_q[CTL_FB]) ? FB_HIGH : FB_LOW);
  endproperty
  a_fb: assert property (p_fb) else $error("feedback ratio");
  property p_oe;
    @(posedge clk) disable iff (!rstn)
      $changed(ctrl_q[CTL_OEB]) |=> bank_b_oe == {2{$past(ctrl_q[CTL_OEB])}}
        && bank_a_oe == $past(ctrl_q[CTL_OEA]);
  endproperty
  a_oe: assert property (p_oe) else $error("enable lag");
  // Complement flops are separate, so the pairing is a real check
  property p_pairs;
    @(posedge clk) disable iff (!rstn) bank_b_out0_true == bank_b_out1_true
      && bank_b_out0_comp == ~bank_b_out1_true;
  endproperty
  a_pairs: assert property (p_pairs) else $error("pairs differ");
  // A smaller ratio only takes hold at the next source edge
  property p_cnt_a;
    @(posedge clk) disable iff (!rstn)
      tick && !mr |=> {1'b0, a_cnt_q} < $past(ratio_a);
  endproperty
  a_cnt_a: assert property (p_cnt_a) else $error("bank A count");
  property p_div2_b;
    @(posedge clk) disable iff (!rstn)
      (ratio_b == DIVB_0) && !mr && tick && (b_cnt_q == 3'h1)
        |=> b_cnt_q == 3'h0 && !b_true_q;
  endproperty
  a_div2_b: assert property (p_div2_b) else $error("bank B wrap");
endmodule

// *** tb/dbc_ref_model.sv ***
// Partner model: free running reference sources that feed the block
`timescale 1ns/1ps
module dbc_ref_model (
  output logic crystal_input,
  output logic ref_clk_in,
  output logic pll_vco_in
);
  // Crystal, period 300 ns, phase unrelated to the system clock
  initial begin
    crystal_input = 1'b0;
    #7;
    forever #150 crystal_input = ~crystal_input;
  end
  // Single-ended reference, period 400 ns
  initial begin
    ref_clk_in = 1'b0;
    #3;
    forever #200 ref_clk_in = ~ref_clk_in;
  end
  // Loop output as seen digitally, period 500 ns
  initial begin
    pll_vco_in = 1'b0;
    #11;
    forever #250 pll_vco_in = ~pll_vco_in;
  end
endmodule

// *** tb/dbc_divider_select_test.sv ***
// Testbench: register access, source selection and output dividers
`timescale 1ns/1ps
module dbc_divider_select_test;
  import dbc_pkg::*;
  logic clk;
  logic rstn;
  dbc_axil_req_t req;
  dbc_axil_rsp_t rsp;
  logic xin, rin, vin, at, ac, aoe, b0t, b0c, b1t, b1c, xd;
  logic [5:0] fb;
  logic [1:0] boe;
  logic [1:0] resp;
  logic [31:0] rdat;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int bad = 0;
  int ra[4] = '{1, 2, 3, 4};
  int rb[4] = '{2, 4, 5, 8};

  dbc_ref_model i_src (.crystal_input(xin), .ref_clk_in(rin),
    .pll_vco_in(vin));
  dbc_divider_select i_dut (.clk(clk), .rstn(rstn), .axi_req(req),
    .axi_rsp(rsp), .crystal_input(xin), .ref_clk_in(rin),
    .pll_vco_in(vin), .crystal_drive_output(xd), .feedback_ratio(fb),
    .bank_a_out_true(at), .bank_a_out_comp(ac), .bank_a_oe(aoe),
    .bank_b_out0_true(b0t), .bank_b_out0_comp(b0c),
    .bank_b_out1_true(b1t), .bank_b_out1_comp(b1c), .bank_b_oe(boe));

  // 40 MHz system clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Hang guard, well above the expected few thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      stop_test;
    end
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h, want %h", $time, got, exp);
    end
  endtask

  // Periods are sampled on the system clock, so allow one cycle of slack
  task check_near(input int got, input int exp);
    total_checks++;
    if (got < exp - 1 || got > exp + 1) begin
      n_errors++;
      $display("wrong value at %0t: %0d cycles, want %0d", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] mk(bit mr, bit byp, bit xs, bit f,
      bit bank_a_output_enable, bit bank_b_output_enable, logic [1:0] da, logic [1:0] db);
    return {22'h0, db, da, bank_b_output_enable, bank_a_output_enable, f, xs, byp, mr};
  endfunction

  // Write: both channels offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    do begin
      @(posedge clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
    resp = rsp.bresp;
  endtask

  task rd(input logic [7:0] a);
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(posedge clk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    req.rready <= 1'b0;
    resp = rsp.rresp;
    rdat = rsp.rdata;
  endtask

  // Cycles between the second and third rise; pairs are watched meanwhile
  task period(input bit b, output int per);
    logic p, c;
    int n, t0, rises;
    n = 0;
    t0 = 0;
    rises = 0;
    p = b ? b0t : at;
    while (rises < 3 && n < 2000) begin
      @(posedge clk);
      c = b ? b0t : at;
      n++;
      if (c === 1'b1 && p === 1'b0) begin
        rises++;
        if (rises == 2) t0 = n;
      end
      if (b0t !== b1t || b0c !== b1c || b0c !== ~b0t || ac !== ~at) bad++;
      p = c;
    end
    per = n - t0;
  endtask

  task t_reset;
    int per;
    rd(CTRL_ADDR);
    check(rdat, 32'h3f6);
    check({26'h0, fb}, 32'h19);
    check({29'h0, aoe, boe}, 32'h7);
    period(1'b0, per);
    check_near(per, 4 * 20);
    period(1'b1, per);
    check_near(per, 8 * 20);
    $display("test reset defaults done");
  endtask

  task t_source;
    int per;
    wr(CTRL_ADDR, mk(0, 0, 0, 0, 1, 1, 2'h3, 2'h3));
    period(1'b0, per);
    check_near(per, 4 * 16);
    check({31'h0, xd}, 32'h0);
    wr(CTRL_ADDR, mk(0, 0, 1, 0, 1, 1, 2'h3, 2'h3));
    period(1'b0, per);
    check_near(per, 4 * 12);
    $display("test source select done");
  endtask

  // Opposite codes per bank show that the selects act independently
  task t_ratio;
    int per;
    for (int s = 0; s < 4; s++) begin
      wr(CTRL_ADDR, mk(0, 0, 0, 0, 1, 1, s[1:0], 2'(3 - s)));
      period(1'b0, per);
      check_near(per, ra[s] * 16);
      period(1'b1, per);
      check_near(per, rb[3 - s] * 16);
    end
    check(bad, 0);
    $display("test divide ratios done");
  endtask

  task t_ctrl;
    wr(CTRL_ADDR, mk(0, 1, 1, 1, 0, 0, 2'h3, 2'h3));
    repeat (2) @(posedge clk);
    check({26'h0, fb}, 32'h20);
    check({29'h0, aoe, boe}, 32'h0);
    wr(CTRL_ADDR, mk(0, 1, 1, 0, 1, 0, 2'h3, 2'h3));
    repeat (2) @(posedge clk);
    check({29'h0, aoe, boe}, 32'h4);
    $display("test enables and feedback done");
  endtask

  task t_mreset;
    int n, ta, tb;
    wr(CTRL_ADDR, mk(1, 0, 0, 0, 1, 1, 2'h3, 2'h3));
    repeat (40) @(posedge clk);
    check({at, ac, b0t, b0c, b1t, b1c}, 32'h15);
    rd(STAT_ADDR);
    check(rdat[ST_MR], 32'h1);
    wr(CTRL_ADDR, mk(0, 0, 0, 0, 1, 1, 2'h3, 2'h3));
    n = 0;
    ta = 0;
    tb = 0;
    while ((ta == 0 || tb == 0) && n < 1000) begin
      @(posedge clk);
      n++;
      if (ta == 0 && at === 1'b1) ta = n;
      if (tb == 0 && b0t === 1'b1) tb = n;
    end
    check_near(tb - ta, 2 * 16);
    $display("test master reset done");
  endtask

  task t_bus;
    rd(8'h08);
    check({resp, rdat[29:0]}, {RESP_SLVERR, 30'h0});
    wr(STAT_ADDR, 32'h0);
    check(resp, RESP_OKAY);
    rd(CTRL_ADDR);
    check(rdat, mk(0, 0, 0, 0, 1, 1, 2'h3, 2'h3));
    $display("test bus responses done");
  endtask

  task stop_test;
    $display("checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    req = '0;
    rstn = 1'b0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    t_reset;
    t_source;
    t_ratio;
    t_ctrl;
    t_mreset;
    t_bus;
    stop_test;
  end
endmodule
